// ===== rtc_regs.svh
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// register byte offsets within the realm page
`define RTC_OFF_CTRL3      12'h02C
`define RTC_OFF_PII_LO     12'h030
`define RTC_OFF_PII_HI     12'h034
`define RTC_OFF_GBPA       12'h044
`define RTC_OFF_AGBPA      12'h048
`define RTC_OFF_IRQ_CTRL   12'h050
`define RTC_OFF_ENABLE     12'h060
`define RTC_OFF_STATUS     12'h064

// field positions
`define RTC_BIT_PTM        2
`define RTC_BIT_RECINV     1
`define RTC_BIT_HOSTSEL    0
`define RTC_BIT_ABORT      20
`define RTC_BIT_EQ_IRQ     2
`define RTC_BIT_PRI_IRQ    1
`define RTC_BIT_GE_IRQ     0

// reset values
`define RTC_RST_CTRL3      3'h4
`define RTC_RST_PII        64'h0000_0000_0000_0000
`define RTC_RST_AGBPA      32'h0000_0000
`define RTC_RST_IRQ        3'h0

// enable update takes this many cycles to be acknowledged
`define RTC_ACK_CYCLES     4'h4

`endif

// ===== rtc_pkg.sv
package rtc_pkg;
    typedef enum logic [1:0] {
        RTC_SEC_NONSECURE,
        RTC_SEC_SECURE,
        RTC_SEC_REALM,
        RTC_SEC_ROOT
    } rtc_sec_t;

    typedef enum logic [3:0] {
        RTC_PERM_NONE,
        RTC_PERM_MRO,
        RTC_PERM_WO,
        RTC_PERM_RO,
        RTC_PERM_RW
    } rtc_perm_class_t;

    typedef struct packed {
        logic            read;
        logic            write;
        logic            exec_user;
        logic            exec_priv;
        rtc_perm_class_t cls;
    } rtc_perm_t;

    typedef struct packed {
        logic private_tlb_maint;
        logic record_invalid_stream;
        logic host_regime_select;
    } rtc_ctrl3_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } rtc_wb_req_t;
endpackage : rtc_pkg

// ===== rtc_perm_decode.sv
`timescale 1ns/1ps
module rtc_perm_decode (
    // table and index
    input  wire logic [63:0]      perm_table,
    input  wire logic [3:0]       permission_index,
    // decoded permission
    output rtc_pkg::rtc_perm_t    perm
);
    import rtc_pkg::*;

    logic [3:0] entry;

    // entry p sits at bits 4p+3..4p
    assign entry = perm_table[{permission_index, 2'b00} +: 4]; // [RULE11]

    always_comb begin
        perm           = '0;
        perm.cls       = RTC_PERM_NONE;
        perm.exec_user = entry[3] & entry[0];
        perm.exec_priv = entry[3] & entry[1];
        unique case (entry)
            4'h0, 4'h1, 4'h5: perm.cls = RTC_PERM_NONE; // [RULE12]
            4'h2, 4'h3, 4'h6, 4'h7: begin
                perm.cls  = RTC_PERM_MRO;
                perm.read = 1'b1;
            end
            4'h4: begin
                perm.cls   = RTC_PERM_WO;
                perm.write = 1'b1;
            end
            4'h8, 4'h9, 4'hA, 4'hB: begin
                perm.cls  = RTC_PERM_RO;
                perm.read = 1'b1;
            end
            4'hC, 4'hD, 4'hE, 4'hF: begin
                perm.cls   = RTC_PERM_RW; // [RULE12]
                perm.read  = 1'b1;
                perm.write = 1'b1;
            end
        endcase
    end
endmodule : rtc_perm_decode

// ===== rtc_realm_ctrl.sv
`timescale 1ns/1ps
`include "rtc_regs.svh"
// Notes on behaviour
// [RULE1] private tlb bit only with broadcast support
// [RULE2] private bit set skips realm broadcast invalidation
// [RULE3] other regimes keep broadcast invalidation unchanged
// [RULE4] record bit gates bad stream events
// [RULE5] host select picks EL2 or EL2-E2H tagging
// [RULE6] host select alters hypervisor realm streams only
// [RULE7] host select may stay cached until invalidated
// [RULE8] software invalidates caches after changing host select
// [RULE9] third control writable only while enable pair clear
// [RULE10] writes during pending enable update are ignored
// [RULE11] sixteen four-bit permission entries, index selected
// [RULE12] permission entries decode to fixed access classes
// [RULE13] permission table optional, else reads zero
// [RULE14] software avoids table writes while indirection live
// [RULE15] global bypass abort bit 20, read only
// [RULE16] alternate bypass bits optional, else zero
// [RULE17] non-realm non-root requester sees zero, writes dropped
// [RULE18] registers decoded at fixed realm page offsets
// [RULE19] interrupt enables bits two one zero, reset zero
// [RULE20] reserved bits read zero, ignore writes
module rtc_realm_ctrl #(
    parameter bit BCAST_MAINT_SUPPORT = 1'b1,
    parameter bit PERM_INDIR_PRESENT  = 1'b1,
    parameter bit ALT_BYPASS_PRESENT  = 1'b1,
    parameter bit PAGE_REQ_PRESENT    = 1'b1
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [11:0]            wb_adr_i,
    input  wire logic [31:0]            wb_dat_i,
    input  rtc_pkg::rtc_sec_t           wb_sec_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // translation side
    input  wire logic                   bcast_inval_i,
    input  wire logic                   bcast_realm_i,
    input  wire logic                   bad_stream_i,
    input  wire logic [1:0]             stream_world_selector,
    input  wire logic                   stream_realm_i,
    input  wire logic [3:0]             permission_index,
    input  wire logic                   global_abort_i,
    output logic                        inval_local_o,
    output logic                        bad_stream_event,
    output logic                        hyp_e2h_o,
    output logic                        hyp_asid_tag_o,
    output rtc_pkg::rtc_perm_t          perm_o,
    output logic                        realm_abort_o,
    output logic      [31:0]            alt_bypass_o,
    output logic      [2:0]             irq_enable_o
);
    import rtc_pkg::*;

    // =========================================================
    // functions
    // =========================================================
    function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : wb_merge

    function automatic logic sec_ok(input rtc_sec_t s);
        return (s == RTC_SEC_REALM) || (s == RTC_SEC_ROOT);
    endfunction : sec_ok

    // =========================================================
    // state
    // =========================================================
    rtc_ctrl3_t  ctrl3_q;
    logic [63:0] pii_q;
    logic [31:0] agbpa_q;
    logic [2:0]  irq_q;
    logic        unit_enable_q;
    logic        enable_acknowledge_q;
    logic [3:0]  ack_cnt_q;
    logic        ack_q;
    logic [31:0] rdata_d;
    logic        abort_sync1_q;
    logic        abort_sync2_q;
    rtc_perm_t   perm_d;

    logic req;
    logic wr;
    logic ctrl3_open;
    logic update_pending;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr  = req & wb_we_i & sec_ok(wb_sec_i); // [RULE17]

    // enable change not yet acknowledged
    assign update_pending = unit_enable_q != enable_acknowledge_q;
    assign ctrl3_open = ~unit_enable_q & ~enable_acknowledge_q; // [RULE9]

    // =========================================================
    // enable and acknowledge pair
    // =========================================================
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            unit_enable_q <= 1'b0;
        end else if (wr && wb_adr_i == `RTC_OFF_ENABLE && wb_sel_i[0]) begin
            unit_enable_q <= wb_dat_i[0];
        end
    end

    // acknowledge follows enable after a fixed settle time
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_cnt_q            <= 4'h0;
            enable_acknowledge_q <= 1'b0;
        end else if (!update_pending) begin
            ack_cnt_q <= 4'h0;
        end else if (ack_cnt_q == `RTC_ACK_CYCLES - 4'h1) begin
            ack_cnt_q            <= 4'h0;
            enable_acknowledge_q <= unit_enable_q;
        end else begin
            ack_cnt_q <= ack_cnt_q + 4'h1;
        end
    end

    // =========================================================
    // third control register
    // =========================================================
    always_ff @(posedge sys_clk or posedge rst) begin
        logic [31:0] m;
        if (rst) begin
            // no broadcast support means the private bit stays reserved
            ctrl3_q <= `RTC_RST_CTRL3 & {BCAST_MAINT_SUPPORT, 2'b11}; // [RULE1]
        end else if (wr && wb_adr_i == `RTC_OFF_CTRL3 // [RULE18]
                     && ctrl3_open && !update_pending) begin // [RULE10]
            m = wb_merge({29'h0, ctrl3_q}, wb_dat_i, wb_sel_i);
            // bit 2 kept zero without broadcast support
            ctrl3_q.private_tlb_maint <= BCAST_MAINT_SUPPORT
                                         & m[`RTC_BIT_PTM]; // [RULE1]
            ctrl3_q.record_invalid_stream <= m[`RTC_BIT_RECINV];
            ctrl3_q.host_regime_select    <= m[`RTC_BIT_HOSTSEL];
        end
    end

    // =========================================================
    // permission table, alternate bypass, irq enables
    // =========================================================
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pii_q <= `RTC_RST_PII;
        end else if (wr && PERM_INDIR_PRESENT) begin // [RULE13]
            if (wb_adr_i == `RTC_OFF_PII_LO) begin
                pii_q[31:0] <= wb_merge(pii_q[31:0], wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == `RTC_OFF_PII_HI) begin
                pii_q[63:32] <= wb_merge(pii_q[63:32], wb_dat_i, wb_sel_i);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            agbpa_q <= `RTC_RST_AGBPA;
        end else if (wr && ALT_BYPASS_PRESENT
                     && wb_adr_i == `RTC_OFF_AGBPA) begin // [RULE16]
            agbpa_q <= wb_merge(agbpa_q, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_q <= `RTC_RST_IRQ; // [RULE19]
        end else if (wr && wb_adr_i == `RTC_OFF_IRQ_CTRL && wb_sel_i[0]) begin
            irq_q[`RTC_BIT_EQ_IRQ]  <= wb_dat_i[`RTC_BIT_EQ_IRQ];
            irq_q[`RTC_BIT_PRI_IRQ] <= PAGE_REQ_PRESENT
                                       & wb_dat_i[`RTC_BIT_PRI_IRQ];
            irq_q[`RTC_BIT_GE_IRQ]  <= wb_dat_i[`RTC_BIT_GE_IRQ];
        end
    end

    // =========================================================
    // read mux and acknowledge
    // =========================================================
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (sec_ok(wb_sec_i)) begin // [RULE17]
            unique case (wb_adr_i)
                `RTC_OFF_CTRL3:    rdata_d = {29'h0, ctrl3_q}; // [RULE20]
                `RTC_OFF_PII_LO:   rdata_d = pii_q[31:0];
                `RTC_OFF_PII_HI:   rdata_d = pii_q[63:32];
                `RTC_OFF_GBPA:     rdata_d[`RTC_BIT_ABORT] = abort_sync2_q; // [RULE15]
                `RTC_OFF_AGBPA:    rdata_d = agbpa_q;
                `RTC_OFF_IRQ_CTRL: rdata_d = {29'h0, irq_q};
                `RTC_OFF_ENABLE:   rdata_d = {31'h0, unit_enable_q};
                `RTC_OFF_STATUS:   rdata_d = {31'h0, enable_acknowledge_q};
                default:           rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // one-cycle answer; unmapped offsets ack with zero data
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_q    <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_q    <= req;
            wb_dat_o <= req ? rdata_d : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_q;

    // =========================================================
    // abort input synchroniser
    // =========================================================
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            abort_sync1_q <= 1'b0;
            abort_sync2_q <= 1'b0;
        end else begin
            abort_sync1_q <= global_abort_i;
            abort_sync2_q <= abort_sync1_q;
        end
    end

    // =========================================================
    // translation side controls
    // =========================================================
    rtc_perm_decode u_perm (
        .perm_table       (pii_q),
        .permission_index (permission_index),
        .perm             (perm_d)
    );

    // host select is sampled live; caches downstream may lag it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            inval_local_o    <= 1'b0;
            bad_stream_event <= 1'b0;
            hyp_e2h_o        <= 1'b0;
            hyp_asid_tag_o   <= 1'b0;
            perm_o           <= '0;
            realm_abort_o    <= 1'b0;
            alt_bypass_o     <= 32'h0000_0000;
            irq_enable_o     <= 3'h0;
        end else begin
            // non-realm regimes always invalidate
            inval_local_o <= bcast_inval_i & (~bcast_realm_i // [RULE3]
                             | ~ctrl3_q.private_tlb_maint); // [RULE2]
            bad_stream_event <= bad_stream_i
                                & ctrl3_q.record_invalid_stream; // [RULE4]
            hyp_e2h_o <= stream_realm_i && stream_world_selector == 2'h2
                         && ctrl3_q.host_regime_select; // [RULE6] [RULE7]
            hyp_asid_tag_o <= stream_realm_i
                              && stream_world_selector == 2'h2
                              && ctrl3_q.host_regime_select; // [RULE5]
            perm_o        <= perm_d; // [RULE11]
            realm_abort_o <= abort_sync2_q;
            alt_bypass_o  <= agbpa_q;
            irq_enable_o  <= irq_q;
        end
    end
endmodule : rtc_realm_ctrl

// ===== rtc_realm_ctrl_assertions.sv
`timescale 1ns/1ps
module rtc_realm_ctrl_assertions (
    // clock and reset
    input logic              sys_clk,
    input logic              rst,
    // bus
    input logic              wb_cyc_i,
    input logic              wb_stb_i,
    input logic              wb_we_i,
    input rtc_pkg::rtc_sec_t wb_sec_i,
    input logic [31:0]       wb_dat_o,
    input logic              wb_ack_o,
    // translation side
    input logic              bcast_inval_i,
    input logic              bcast_realm_i,
    input logic              bad_stream_i,
    input logic [1:0]        stream_world_selector,
    input logic              stream_realm_i,
    input logic              global_abort_i,
    input logic              inval_local_o,
    input logic              bad_stream_event,
    input logic              hyp_e2h_o,
    input logic              hyp_asid_tag_o,
    input rtc_pkg::rtc_perm_t perm_o,
    input logic              realm_abort_o
);
    import rtc_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // =========================================
    // bus answer
    property p_ack_one;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("request not answered in one cycle");
    property p_ack_drop;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("ack held longer than one cycle");
    property p_sec_raz;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
        !(wb_sec_i inside {RTC_SEC_REALM, RTC_SEC_ROOT})
        |=> wb_dat_o == 32'h0000_0000;
    endproperty
    a_sec_raz: assert property (p_sec_raz)
        else $error("outside requester read nonzero data");
    // =========================================
    // translation side
    property p_other_regime;
        bcast_inval_i && !bcast_realm_i |=> inval_local_o;
    endproperty
    a_other_regime: assert property (p_other_regime)
        else $error("non realm broadcast not invalidated");
    property p_no_cause;
        !bad_stream_i |=> !bad_stream_event;
    endproperty
    a_no_cause: assert property (p_no_cause)
        else $error("bad stream event without cause");
    property p_hyp_only;
        !(stream_realm_i && stream_world_selector == 2'h2) |=> !hyp_e2h_o;
    endproperty
    a_hyp_only: assert property (p_hyp_only)
        else $error("host regime applied to wrong stream");
    property p_hyp_tag;
        hyp_e2h_o == hyp_asid_tag_o;
    endproperty
    a_hyp_tag: assert property (p_hyp_tag)
        else $error("asid tagging differs from host regime");
    property p_perm_rw;
        perm_o.cls == RTC_PERM_RW |-> perm_o.read && perm_o.write;
    endproperty
    a_perm_rw: assert property (p_perm_rw)
        else $error("read write class lacks access");
    // two sync flops plus the output flop; five cycles leaves margin
    property p_abort;
        global_abort_i [*5] |-> realm_abort_o;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort input not reflected");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_event: cover property (bad_stream_event);
    c_hyp:   cover property (hyp_e2h_o);
endmodule : rtc_realm_ctrl_assertions

bind rtc_realm_ctrl rtc_realm_ctrl_assertions i_rtc_realm_ctrl_assertions (
    .sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sec_i, .wb_dat_o,
    .wb_ack_o, .bcast_inval_i, .bcast_realm_i, .bad_stream_i,
    .stream_world_selector, .stream_realm_i, .global_abort_i,
    .inval_local_o, .bad_stream_event, .hyp_e2h_o, .hyp_asid_tag_o,
    .perm_o, .realm_abort_o
);

// ===== rtc_realm_ctrl_test.sv
`timescale 1ns/1ps
module rtc_realm_ctrl_test;
    import rtc_pkg::*;
    localparam rtc_sec_t SR = RTC_SEC_REALM;
    localparam rtc_sec_t SN = RTC_SEC_NONSECURE;
    logic sys_clk = 1'b0, rst = 1'b1, ack, ev, hyp, asid, inv, ab;
    logic bci = 1'b0, bcr = 1'b0, bsi = 1'b0, srl = 1'b0, gab = 1'b0;
    logic [1:0]  sws = 2'h0;
    logic [3:0]  pidx = 4'h0;
    logic [31:0] q, alt;
    logic [2:0]  irq;
    rtc_sec_t    sec = SR;
    rtc_wb_req_t req = '0;
    rtc_perm_t   perm;
    int n_fail = 0, checks = 0;
    always #5 sys_clk = ~sys_clk;
    rtc_realm_ctrl i_rtc_realm_ctrl (.sys_clk(sys_clk), .rst(rst),
        .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
        .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
        .wb_sec_i(sec), .wb_dat_o(q), .wb_ack_o(ack),
        .bcast_inval_i(bci), .bcast_realm_i(bcr), .bad_stream_i(bsi),
        .stream_world_selector(sws), .stream_realm_i(srl),
        .permission_index(pidx), .global_abort_i(gab),
        .inval_local_o(inv), .bad_stream_event(ev), .hyp_e2h_o(hyp),
        .hyp_asid_tag_o(asid), .perm_o(perm), .realm_abort_o(ab),
        .alt_bypass_o(alt), .irq_enable_o(irq));
    // =========================================
    // helpers
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(logic we, rtc_sec_t s, logic [11:0] a,
                       logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge sys_clk);
        req <= '{1'b1, 1'b1, we, 4'hF, a, d};
        sec <= s;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            $display("[ERR] wb_ack_o expected 1 seen %b", ack);
            n_fail++;
            finish_test();
        end
        r = q;
        req <= '0;
    endtask : bus
    task automatic wr(rtc_sec_t s, logic [11:0] a, logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, s, a, d, r);
    endtask : wr
    task automatic rc(string nm, rtc_sec_t s, logic [11:0] a,
                      logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, s, a, 32'h0, r);
        chk(nm, e, r);
    endtask : rc
    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic wait_ack(logic e);
        logic [31:0] r;
        int n;
        n = 0;
        do begin
            bus(1'b0, SR, 12'h064, 32'h0, r);
            n++;
        end while (r[0] !== e && n < 10);
        chk("enable_acknowledge", {31'h0, e}, {31'h0, r[0]});
    endtask : wait_ack
    task automatic pulse_bad(logic e);
        bsi <= 1'b1;
        @(posedge sys_clk);
        bsi <= 1'b0;
        #1;
        chk("bad_stream_event", {31'h0, e}, {31'h0, ev});
    endtask : pulse_bad
    function automatic rtc_perm_class_t cls_of(logic [3:0] e);
        case (e)
            4'h2, 4'h3, 4'h6, 4'h7: return RTC_PERM_MRO;
            4'h4: return RTC_PERM_WO;
            default: return e[3] ? (e[2] ? RTC_PERM_RW : RTC_PERM_RO)
                                 : RTC_PERM_NONE;
        endcase
    endfunction : cls_of
    // =========================================
    // scenarios
    task automatic t_regs;
        chk("irq_enable_o", 32'h0, {29'h0, irq});
        rc("ctrl3_reset", SR, 12'h02C, 32'h0000_0004);
        rc("irq_reset", SR, 12'h050, 32'h0);
        wr(SR, 12'h030, 32'hA5A5_1234);
        wr(RTC_SEC_ROOT, 12'h034, 32'h0F0F_F0F0);
        wr(SR, 12'h048, 32'hDEAD_BEEF);
        wr(SN, 12'h048, 32'h1111_1111);
        wr(RTC_SEC_SECURE, 12'h030, 32'h0);
        rc("pii_lo", SR, 12'h030, 32'hA5A5_1234);
        rc("pii_hi", RTC_SEC_ROOT, 12'h034, 32'h0F0F_F0F0);
        rc("alt_bypass", SR, 12'h048, 32'hDEAD_BEEF);
        chk("alt_bypass_o", 32'hDEAD_BEEF, alt);
        rc("alt_outside", SN, 12'h048, 32'h0);
        rc("unmapped", SR, 12'h0FC, 32'h0);
        gab <= 1'b1;
        repeat (6) @(posedge sys_clk);
        wr(SR, 12'h044, 32'h0);
        rc("bypass_abort", SR, 12'h044, 32'h0010_0000);
        chk("realm_abort_o", 32'h1, {31'h0, ab});
        gab <= 1'b0;
        wr(SR, 12'h050, 32'hFFFF_FFFF);
        rc("irq_rw", SR, 12'h050, 32'h0000_0007);
        chk("irq_enable_o", 32'h7, {29'h0, irq});
        $display("done t_regs");
    endtask : t_regs
    task automatic t_ctrl3;
        wr(SR, 12'h02C, 32'hFFFF_FFF8);
        rc("ctrl3_reserved", SR, 12'h02C, 32'h0);
        wr(SR, 12'h060, 32'h1);
        wr(SR, 12'h02C, 32'h7);
        rc("ctrl3_pending", SR, 12'h02C, 32'h0);
        wait_ack(1'b1);
        wr(SR, 12'h02C, 32'h7);
        rc("ctrl3_locked", SR, 12'h02C, 32'h0);
        wr(SR, 12'h060, 32'h0);
        wait_ack(1'b0);
        wr(SR, 12'h02C, 32'h7);
        rc("ctrl3_open", SR, 12'h02C, 32'h7);
        $display("done t_ctrl3");
    endtask : t_ctrl3
    task automatic t_side;
        bci <= 1'b1;
        bcr <= 1'b1;
        srl <= 1'b1;
        sws <= 2'h2;
        settle();
        chk("inval_private", 32'h0, {31'h0, inv});
        chk("hyp_e2h_o", 32'h1, {31'h0, hyp});
        chk("hyp_asid_tag_o", 32'h1, {31'h0, asid});
        bcr <= 1'b0;
        sws <= 2'h1;
        settle();
        chk("inval_other", 32'h1, {31'h0, inv});
        chk("hyp_other_world", 32'h0, {31'h0, hyp});
        pulse_bad(1'b1);
        wr(SR, 12'h02C, 32'h0);
        bcr <= 1'b1;
        sws <= 2'h2;
        settle();
        chk("inval_shared", 32'h1, {31'h0, inv});
        chk("hyp_plain", 32'h0, {31'h0, asid});
        pulse_bad(1'b0);
        $display("done t_side");
    endtask : t_side
    task automatic t_perm;
        wr(SR, 12'h030, 32'h7654_3210);
        wr(SR, 12'h034, 32'hFEDC_BA98);
        for (int p = 0; p < 16; p++) begin
            pidx <= 4'(p);
            settle();
            chk("perm_cls", {28'h0, cls_of(4'(p))}, {28'h0, perm.cls});
            chk("perm_rd_wr", {30'h0,
                cls_of(4'(p)) inside {RTC_PERM_MRO, RTC_PERM_RO, RTC_PERM_RW},
                cls_of(4'(p)) inside {RTC_PERM_WO, RTC_PERM_RW}},
                {30'h0, perm.read, perm.write});
            if (p >= 8)
                chk("perm_exec", {30'h0, 2'(p)},
                    {30'h0, perm.exec_priv, perm.exec_user});
        end
        $display("done t_perm");
    endtask : t_perm
    // =========================================
    // run
    task automatic finish_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_ctrl3();
        t_side();
        t_perm();
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        finish_test();
    end
endmodule : rtc_realm_ctrl_test
